// *** emsp_pkg.sv ***
// types of the endpoint messaging stream port
`include "emsp_regs.svh"
package emsp_pkg;
  typedef logic [`EMSP_DATA_W-1:0] emsp_data_type;
  typedef logic [`EMSP_USER_W-1:0] emsp_user_type;
  typedef logic [`EMSP_KEEP_W-1:0] emsp_keep_type;
  typedef enum {
    EMSP_CH_IREQ,
    EMSP_CH_IRESP,
    EMSP_CH_TREQ,
    EMSP_CH_TRESP
  } emsp_chan_type;
  typedef struct packed {
    emsp_data_type data;
    logic last;
    emsp_user_type user;
  } emsp_beat_type;
endpackage : emsp_pkg

// *** emsp_port.sv ***
// messaging port: four stream channels between user logic and the link path
`timescale 1ns/100ps
`include "emsp_regs.svh"
module emsp_port
  import emsp_pkg::*;
#(
  parameter bit MSG_PORT_EN = 1'b1,
  parameter bit ID8_MODE = 1'b0
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  // initiator request, user to device
  input wire logic s_axis_msgireq_tvalid_in,
  output logic s_axis_msgireq_tready_out,
  input wire logic [63:0] s_axis_msgireq_tdata_in,
  input wire logic [7:0] s_axis_msgireq_tkeep_in,
  input wire logic s_axis_msgireq_tlast_in,
  input wire logic [31:0] s_axis_msgireq_tuser_in,
  // initiator response, device to user
  output logic m_axis_msgiresp_tvalid_out,
  input wire logic m_axis_msgiresp_tready_in,
  output logic [63:0] m_axis_msgiresp_tdata_out,
  output logic [7:0] m_axis_msgiresp_tkeep_out,
  output logic m_axis_msgiresp_tlast_out,
  output logic [31:0] m_axis_msgiresp_tuser_out,
  // target request, device to user
  output logic m_axis_msgtreq_tvalid_out,
  input wire logic m_axis_msgtreq_tready_in,
  output logic [63:0] m_axis_msgtreq_tdata_out,
  output logic [7:0] m_axis_msgtreq_tkeep_out,
  output logic m_axis_msgtreq_tlast_out,
  output logic [31:0] m_axis_msgtreq_tuser_out,
  // target response, user to device
  input wire logic s_axis_msgtresp_tvalid_in,
  output logic s_axis_msgtresp_tready_out,
  input wire logic [63:0] s_axis_msgtresp_tdata_in,
  input wire logic [7:0] s_axis_msgtresp_tkeep_in,
  input wire logic s_axis_msgtresp_tlast_in,
  input wire logic [31:0] s_axis_msgtresp_tuser_in,
  // link path: outbound request
  output logic lnk_txreq_valid_out,
  input wire logic lnk_txreq_ready_in,
  output logic [63:0] lnk_txreq_data_out,
  output logic lnk_txreq_last_out,
  output logic [31:0] lnk_txreq_user_out,
  // link path: outbound response
  output logic lnk_txresp_valid_out,
  input wire logic lnk_txresp_ready_in,
  output logic [63:0] lnk_txresp_data_out,
  output logic lnk_txresp_last_out,
  output logic [31:0] lnk_txresp_user_out,
  // link path: inbound request
  input wire logic lnk_rxreq_valid_in,
  output logic lnk_rxreq_ready_out,
  input wire logic [63:0] lnk_rxreq_data_in,
  input wire logic lnk_rxreq_last_in,
  input wire logic [31:0] lnk_rxreq_user_in,
  // link path: inbound response
  input wire logic lnk_rxresp_valid_in,
  output logic lnk_rxresp_ready_out,
  input wire logic [63:0] lnk_rxresp_data_in,
  input wire logic lnk_rxresp_last_in,
  input wire logic [31:0] lnk_rxresp_user_in,
  // sticky per channel: user beat taken with tkeep not all ones
  output logic [3:0] keep_err_out
);
  localparam int NCH = `EMSP_NUM_CH;

  // ************************************************************
  // channel routing
  // ************************************************************
  // each channel has its own slice, so initiator and target traffic never mix
  logic [NCH-1:0] in_valid, in_last, in_ready;
  logic [NCH-1:0] out_valid_w, out_ready, out_last;
  emsp_data_type in_data [NCH];
  emsp_user_type in_user [NCH];
  emsp_keep_type in_keep [NCH];
  emsp_data_type out_data [NCH];
  emsp_user_type out_user [NCH];

  always_comb begin
    in_valid[EMSP_CH_IREQ] = s_axis_msgireq_tvalid_in;
    in_data[EMSP_CH_IREQ] = s_axis_msgireq_tdata_in;
    in_keep[EMSP_CH_IREQ] = s_axis_msgireq_tkeep_in;
    in_last[EMSP_CH_IREQ] = s_axis_msgireq_tlast_in;
    in_user[EMSP_CH_IREQ] = s_axis_msgireq_tuser_in;
    in_valid[EMSP_CH_IRESP] = lnk_rxresp_valid_in;
    in_data[EMSP_CH_IRESP] = lnk_rxresp_data_in;
    in_keep[EMSP_CH_IRESP] = `EMSP_KEEP_ALL;
    in_last[EMSP_CH_IRESP] = lnk_rxresp_last_in;
    in_user[EMSP_CH_IRESP] = lnk_rxresp_user_in;
    in_valid[EMSP_CH_TREQ] = lnk_rxreq_valid_in;
    in_data[EMSP_CH_TREQ] = lnk_rxreq_data_in;
    in_keep[EMSP_CH_TREQ] = `EMSP_KEEP_ALL;
    in_last[EMSP_CH_TREQ] = lnk_rxreq_last_in;
    in_user[EMSP_CH_TREQ] = lnk_rxreq_user_in;
    in_valid[EMSP_CH_TRESP] = s_axis_msgtresp_tvalid_in;
    in_data[EMSP_CH_TRESP] = s_axis_msgtresp_tdata_in;
    in_keep[EMSP_CH_TRESP] = s_axis_msgtresp_tkeep_in;
    in_last[EMSP_CH_TRESP] = s_axis_msgtresp_tlast_in;
    in_user[EMSP_CH_TRESP] = s_axis_msgtresp_tuser_in;
    out_ready[EMSP_CH_IREQ] = lnk_txreq_ready_in;
    out_ready[EMSP_CH_IRESP] = m_axis_msgiresp_tready_in;
    out_ready[EMSP_CH_TREQ] = m_axis_msgtreq_tready_in;
    out_ready[EMSP_CH_TRESP] = lnk_txresp_ready_in;
  end

  // ************************************************************
  // per-channel beat handling
  // ************************************************************
  logic [NCH-1:0] first_ff, nxt_first;
  logic [NCH-1:0] err_ff, nxt_err;
  logic [NCH-1:0] acc;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      emsp_user_type shaped_user;
      logic gated_valid, sl_ready;
      emsp_beat_type in_beat, out_beat;

      // later beats carry zero tuser, so nothing downstream can lean on it
      always_comb begin
        shaped_user = first_ff[c] ? in_user[c] : `EMSP_USER_ZERO;
        if (ID8_MODE) begin
          shaped_user = shaped_user & `EMSP_ID8_MASK;
        end
        in_beat.data = in_data[c];
        in_beat.last = in_last[c];
        in_beat.user = shaped_user;
      end

      // with the port absent nothing is taken, so no beat enters or leaves any slice
      assign gated_valid = in_valid[c] & MSG_PORT_EN;
      assign in_ready[c] = sl_ready & MSG_PORT_EN;
      assign acc[c] = gated_valid & sl_ready;
      // each channel drives only its own bit, so the shared vectors keep one driver per bit
      assign nxt_first[c] = acc[c] ? in_last[c] : first_ff[c];
      assign nxt_err[c] = err_ff[c] | (acc[c] & (in_keep[c] != `EMSP_KEEP_ALL));
      assign out_data[c] = out_beat.data;
      assign out_last[c] = out_beat.last;
      assign out_user[c] = out_beat.user;

      emsp_slice #(
        .W($bits(emsp_beat_type))
      ) u_slice (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .s_valid_in(gated_valid),
        .s_ready_out(sl_ready),
        .s_payload_in(in_beat),
        .m_valid_out(out_valid_w[c]),
        .m_ready_in(out_ready[c]),
        .m_payload_out(out_beat)
      );
    end
  endgenerate

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      first_ff <= '1;
      err_ff <= '0;
    end else begin
      first_ff <= nxt_first;
      err_ff <= nxt_err;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // the slices hold valid low from reset and the payload steady until taken
  assign s_axis_msgireq_tready_out = in_ready[EMSP_CH_IREQ];
  assign s_axis_msgtresp_tready_out = in_ready[EMSP_CH_TRESP];
  assign lnk_rxreq_ready_out = in_ready[EMSP_CH_TREQ];
  assign lnk_rxresp_ready_out = in_ready[EMSP_CH_IRESP];

  assign lnk_txreq_valid_out = out_valid_w[EMSP_CH_IREQ];
  assign lnk_txreq_data_out = out_data[EMSP_CH_IREQ];
  assign lnk_txreq_last_out = out_last[EMSP_CH_IREQ];
  assign lnk_txreq_user_out = out_user[EMSP_CH_IREQ];
  assign lnk_txresp_valid_out = out_valid_w[EMSP_CH_TRESP];
  assign lnk_txresp_data_out = out_data[EMSP_CH_TRESP];
  assign lnk_txresp_last_out = out_last[EMSP_CH_TRESP];
  assign lnk_txresp_user_out = out_user[EMSP_CH_TRESP];

  assign m_axis_msgiresp_tvalid_out = out_valid_w[EMSP_CH_IRESP];
  assign m_axis_msgiresp_tdata_out = out_data[EMSP_CH_IRESP];
  assign m_axis_msgiresp_tlast_out = out_last[EMSP_CH_IRESP];
  assign m_axis_msgiresp_tuser_out = out_user[EMSP_CH_IRESP];
  assign m_axis_msgtreq_tvalid_out = out_valid_w[EMSP_CH_TREQ];
  assign m_axis_msgtreq_tdata_out = out_data[EMSP_CH_TREQ];
  assign m_axis_msgtreq_tlast_out = out_last[EMSP_CH_TREQ];
  assign m_axis_msgtreq_tuser_out = out_user[EMSP_CH_TREQ];

  // header-encoded format only: every beat has all lanes valid
  assign m_axis_msgiresp_tkeep_out = `EMSP_KEEP_ALL;
  assign m_axis_msgtreq_tkeep_out = `EMSP_KEEP_ALL;
  assign keep_err_out = err_ff;
endmodule : emsp_port

// *** emsp_port_sva.sv ***
// checker of the messaging port
`timescale 1ns/100ps
module emsp_port_sva (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic lnk_rxresp_valid_in,
  input wire logic lnk_rxresp_ready_out,
  input wire logic [63:0] lnk_rxresp_data_in,
  input wire logic m_axis_msgiresp_tvalid_out,
  input wire logic m_axis_msgiresp_tready_in,
  input wire logic [63:0] m_axis_msgiresp_tdata_out,
  input wire logic [7:0] m_axis_msgiresp_tkeep_out,
  input wire logic s_axis_msgireq_tvalid_in,
  input wire logic s_axis_msgireq_tready_out,
  input wire logic [7:0] s_axis_msgireq_tkeep_in,
  input wire logic lnk_txreq_valid_out,
  input wire logic lnk_txreq_ready_in,
  input wire logic [3:0] keep_err_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence rsp_in; lnk_rxresp_valid_in && lnk_rxresp_ready_out; endsequence
  sequence req_in; s_axis_msgireq_tvalid_in && s_axis_msgireq_tready_out; endsequence
  resp_hold_a: assert property (m_axis_msgiresp_tvalid_out && !m_axis_msgiresp_tready_in
    |=> m_axis_msgiresp_tvalid_out && $stable(m_axis_msgiresp_tdata_out)) else $error("resp hold");
  txreq_hold_a: assert property (lnk_txreq_valid_out && !lnk_txreq_ready_in
    |=> lnk_txreq_valid_out) else $error("txreq hold");
  resp_keep_a: assert property (m_axis_msgiresp_tkeep_out == 8'hff) else $error("keep");
  resp_pass_a: assert property (rsp_in ##0 !m_axis_msgiresp_tvalid_out |=>
    m_axis_msgiresp_tvalid_out && m_axis_msgiresp_tdata_out == $past(lnk_rxresp_data_in))
    else $error("resp pass");
  req_pass_a: assert property (req_in ##0 !lnk_txreq_valid_out |=> lnk_txreq_valid_out)
    else $error("req pass");
  keep_flag_a: assert property (req_in ##0 s_axis_msgireq_tkeep_in != 8'hff
    |=> keep_err_out[0]) else $error("keep flag");
  keep_clean_a: assert property (!keep_err_out[0] && !(s_axis_msgireq_tvalid_in
    && s_axis_msgireq_tkeep_in != 8'hff) |=> !keep_err_out[0]) else $error("keep clean");
  rst_idle_a: assert property (!$past(arst_n_in) |-> !m_axis_msgiresp_tvalid_out
    && !lnk_txreq_valid_out && keep_err_out == 4'h0 ##1 s_axis_msgireq_tready_out)
    else $error("reset idle");
endmodule : emsp_port_sva
bind emsp_port emsp_port_sva sva_i (.*);

// *** emsp_regs.svh ***
// constants of the endpoint messaging stream port
`ifndef EMSP_REGS_SVH
`define EMSP_REGS_SVH
`define EMSP_DATA_W 64
`define EMSP_KEEP_W 8
`define EMSP_USER_W 32
`define EMSP_KEEP_ALL 8'hff
`define EMSP_USER_ZERO 32'h0000_0000
`define EMSP_SRC_ID_LSB 16
`define EMSP_ID8_MASK 32'h00ff_00ff
`define EMSP_NUM_CH 4
`endif

// *** emsp_slice.sv ***
// two-entry register slice with registered ready and valid
`timescale 1ns/100ps
module emsp_slice #(
  parameter int W = 97
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic s_valid_in,
  output logic s_ready_out,
  input wire logic [W-1:0] s_payload_in,
  output logic m_valid_out,
  input wire logic m_ready_in,
  output logic [W-1:0] m_payload_out
);
  logic main_v_ff, nxt_main_v;
  logic skid_v_ff, nxt_skid_v;
  logic rdy_ff, nxt_rdy;
  logic [W-1:0] main_ff, nxt_main;
  logic [W-1:0] skid_ff, nxt_skid;
  logic acc, pop;

  // the skid entry lets ready be a flop without losing a beat
  always_comb begin
    acc = s_valid_in & rdy_ff;
    pop = ~main_v_ff | m_ready_in;
    nxt_main_v = main_v_ff;
    nxt_main = main_ff;
    nxt_skid_v = skid_v_ff;
    nxt_skid = skid_ff;
    if (pop) begin
      if (skid_v_ff) begin
        nxt_main = skid_ff;
        nxt_main_v = 1'b1;
        nxt_skid_v = 1'b0;
      end else begin
        nxt_main_v = acc;
        if (acc) begin
          nxt_main = s_payload_in;
        end
      end
    end else if (acc) begin
      nxt_skid = s_payload_in;
      nxt_skid_v = 1'b1;
    end
    nxt_rdy = ~nxt_skid_v;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      main_v_ff <= 1'b0;
      skid_v_ff <= 1'b0;
      rdy_ff <= 1'b0;
      main_ff <= '0;
      skid_ff <= '0;
    end else begin
      main_v_ff <= nxt_main_v;
      skid_v_ff <= nxt_skid_v;
      rdy_ff <= nxt_rdy;
      main_ff <= nxt_main;
      skid_ff <= nxt_skid;
    end
  end

  assign s_ready_out = rdy_ff;
  assign m_valid_out = main_v_ff;
  assign m_payload_out = main_ff;
endmodule : emsp_slice

// *** emsp_user_model.sv ***
// user-side model: takes target requests and answers each one
`timescale 1ns/100ps
module emsp_user_model
  import emsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic slow_in,
  input wire logic rq_valid_in,
  output logic rq_ready_out,
  input wire emsp_beat_type rq_beat_in,
  output logic rs_valid_out,
  input wire logic rs_ready_in,
  output emsp_beat_type rs_beat_out
);
  emsp_beat_type q[$];
  logic [1:0] cnt_ff;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q.delete();
      cnt_ff <= 2'h0;
      rq_ready_out <= 1'h0;
      rs_valid_out <= 1'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      rq_ready_out <= !slow_in || cnt_ff[1];
      if (rs_valid_out && rs_ready_in) void'(q.pop_front());
      // answer swaps source and destination ids of the request
      if (rq_valid_in && rq_ready_out) q.push_back({rq_beat_in[96:32], rq_beat_in[15:0],
        rq_beat_in[31:16]});
      rs_valid_out <= q.size() != 0;
      // idle lines toggle so a stale beat never looks valid
      rs_beat_out <= (q.size() != 0) ? q[0] : {cnt_ff[0], {48{cnt_ff}}};
    end
  end
endmodule : emsp_user_model

// *** tb.sv ***
// testbench of the messaging port
`timescale 1ns/100ps
module tb;
  import emsp_pkg::*;
  typedef struct {emsp_data_type d; logic l; emsp_user_type u; emsp_user_type eu;} emsp_row_type;
  emsp_row_type rows[4] = '{'{64'h0123_4567_89ab_cdef, 1'h0, 32'h0001_0002, 32'h0001_0002},
    '{64'hfedc_ba98_7654_3210, 1'h0, 32'hdead_beef, 32'h0},
    '{64'h0000_0000_0000_0001, 1'h1, 32'h5555_aaaa, 32'h0},
    '{64'h8000_0000_0000_0000, 1'h1, 32'hab03_cd04, 32'hab03_cd04}};
  emsp_row_type exp_q[$];
  int failures = 0;
  int total_checks = 0;
  int ix[3] = '{0, 0, 0};
  logic clk_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic slow = 1'h0;
  logic bl = 1'h0;
  logic [2:0] v = 3'h0;
  logic [2:0] rdy = 3'h7;
  emsp_data_type bd = 64'h0;
  emsp_user_type bu = 32'h0;
  emsp_keep_type bk = 8'hff;
  wire emsp_beat_type rs_beat;
  wire logic s_axis_msgireq_tvalid_in = v[0], lnk_rxresp_valid_in = v[1], lnk_rxreq_valid_in = v[2];
  wire logic [63:0] s_axis_msgireq_tdata_in = bd, lnk_rxresp_data_in = bd, lnk_rxreq_data_in = bd;
  wire logic s_axis_msgireq_tlast_in = bl, lnk_rxresp_last_in = bl, lnk_rxreq_last_in = bl;
  wire logic [31:0] s_axis_msgireq_tuser_in = bu, lnk_rxresp_user_in = bu, lnk_rxreq_user_in = bu;
  wire logic [7:0] s_axis_msgireq_tkeep_in = bk, s_axis_msgtresp_tkeep_in = 8'hff;
  wire logic m_axis_msgiresp_tready_in = rdy[0], lnk_txreq_ready_in = rdy[1];
  wire logic lnk_txresp_ready_in = rdy[2], s_axis_msgtresp_tvalid_in, m_axis_msgtreq_tready_in;
  wire logic [63:0] s_axis_msgtresp_tdata_in = rs_beat.data;
  wire logic s_axis_msgtresp_tlast_in = rs_beat.last;
  wire logic [31:0] s_axis_msgtresp_tuser_in = rs_beat.user;
  wire logic s_axis_msgireq_tready_out, m_axis_msgiresp_tvalid_out, m_axis_msgiresp_tlast_out;
  wire logic m_axis_msgtreq_tvalid_out, m_axis_msgtreq_tlast_out, s_axis_msgtresp_tready_out;
  wire logic lnk_txreq_valid_out, lnk_txreq_last_out, lnk_txresp_valid_out, lnk_txresp_last_out;
  wire logic lnk_rxreq_ready_out, lnk_rxresp_ready_out;
  wire logic [63:0] m_axis_msgiresp_tdata_out, m_axis_msgtreq_tdata_out;
  wire logic [63:0] lnk_txreq_data_out, lnk_txresp_data_out;
  wire logic [31:0] m_axis_msgiresp_tuser_out, m_axis_msgtreq_tuser_out;
  wire logic [31:0] lnk_txreq_user_out, lnk_txresp_user_out;
  wire logic [7:0] m_axis_msgiresp_tkeep_out, m_axis_msgtreq_tkeep_out;
  wire logic [3:0] keep_err_out;
  wire logic [31:0] id8_user;
  emsp_port dut (.*);
  // same traffic through an 8-bit id build; only its request-side tuser is watched
  emsp_port #(.ID8_MODE(1'b1)) dut_id8 (.*, .s_axis_msgireq_tready_out(),
    .m_axis_msgiresp_tvalid_out(), .m_axis_msgiresp_tdata_out(), .m_axis_msgiresp_tkeep_out(),
    .m_axis_msgiresp_tlast_out(), .m_axis_msgiresp_tuser_out(), .m_axis_msgtreq_tvalid_out(),
    .m_axis_msgtreq_tdata_out(), .m_axis_msgtreq_tkeep_out(), .m_axis_msgtreq_tlast_out(),
    .m_axis_msgtreq_tuser_out(), .s_axis_msgtresp_tready_out(), .lnk_txreq_valid_out(),
    .lnk_txreq_data_out(), .lnk_txreq_last_out(), .lnk_txreq_user_out(id8_user),
    .lnk_txresp_valid_out(), .lnk_txresp_data_out(), .lnk_txresp_last_out(),
    .lnk_txresp_user_out(), .lnk_rxreq_ready_out(), .lnk_rxresp_ready_out(), .keep_err_out());
  emsp_user_model partner (.clk_in(clk_in), .arst_n_in(arst_n_in), .slow_in(slow),
    .rq_valid_in(m_axis_msgtreq_tvalid_out), .rq_ready_out(m_axis_msgtreq_tready_in),
    .rq_beat_in({m_axis_msgtreq_tdata_out, m_axis_msgtreq_tlast_out, m_axis_msgtreq_tuser_out}),
    .rs_valid_out(s_axis_msgtresp_tvalid_in), .rs_ready_in(s_axis_msgtresp_tready_out),
    .rs_beat_out(rs_beat));
  always #4 clk_in = ~clk_in;
  // stall pattern walks all ready combinations when slow
  always @(negedge clk_in) rdy <= slow ? rdy + 3'h3 : 3'h7;
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'h1) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic cmp(input int c, input emsp_data_type d, input logic l, input emsp_user_type u);
    emsp_row_type e;
    e = exp_q[ix[c]];
    ix[c]++;
    if (c == 0) chk(id8_user === (e.eu & 32'h00ff_00ff), "id8 user");
    if (c == 2) e.eu = {e.eu[15:0], e.eu[31:16]};
    chk(d === e.d && l === e.l && u === e.eu, "beat mismatch");
  endtask : cmp
  // sampled just before the edge, once ready has settled
  always @(negedge clk_in) begin
    #2;
    if (lnk_txreq_valid_out && rdy[1]) cmp(0, lnk_txreq_data_out, lnk_txreq_last_out,
      lnk_txreq_user_out);
    if (m_axis_msgiresp_tvalid_out && rdy[0]) cmp(1, m_axis_msgiresp_tdata_out,
      m_axis_msgiresp_tlast_out, m_axis_msgiresp_tuser_out);
    if (lnk_txresp_valid_out && rdy[2]) cmp(2, lnk_txresp_data_out, lnk_txresp_last_out,
      lnk_txresp_user_out);
    if (m_axis_msgtreq_tvalid_out) chk(m_axis_msgtreq_tkeep_out === 8'hff, "keep");
    if (m_axis_msgiresp_tvalid_out) chk(m_axis_msgiresp_tkeep_out === 8'hff, "keep");
  end
  task automatic send(input emsp_row_type r, input emsp_keep_type k);
    logic [2:0] g;
    bd = r.d;
    bl = r.l;
    bu = r.u;
    bk = k;
    v = 3'h7;
    exp_q.push_back(r);
    for (int n = 0; n < 60; n++) begin
      g = {lnk_rxreq_ready_out, lnk_rxresp_ready_out, s_axis_msgireq_tready_out};
      @(negedge clk_in);
      if ((v & ~g) == 3'h0) break;
      v = v & ~g;
    end
  endtask : send
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    #100000;
    failures++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge clk_in);
    chk(m_axis_msgiresp_tvalid_out === 1'h0 && lnk_txreq_valid_out === 1'h0 &&
      s_axis_msgireq_tready_out === 1'h0 && keep_err_out === 4'h0, "reset");
    arst_n_in = 1'h1;
    // pass 1 stalls every side and spoils the byte qualifier of one beat
    for (int p = 0; p < 2; p++) begin
      slow = p[0];
      foreach (rows[i]) send(rows[i], (p == 1 && i == 3) ? 8'h0f : 8'hff);
      v = 3'h0;
      for (int n = 0; n < 300 && ix[0] + ix[1] + ix[2] != 3 * exp_q.size(); n++)
        @(negedge clk_in);
      chk(ix[0] + ix[1] + ix[2] == 3 * exp_q.size(), "beats lost");
      $display("stream test %0d done", p);
    end
    chk(keep_err_out === 4'h1, "keep flag");
    arst_n_in = 1'h0;
    repeat (2) @(negedge clk_in);
    chk(keep_err_out === 4'h0 && s_axis_msgireq_tready_out === 1'h0, "second reset");
    arst_n_in = 1'h1;
    send(rows[3], 8'hff);
    v = 3'h0;
    for (int n = 0; n < 300 && ix[0] + ix[1] + ix[2] != 3 * exp_q.size(); n++)
      @(negedge clk_in);
    chk(ix[0] + ix[1] + ix[2] == 3 * exp_q.size(), "beats lost after reset");
    $display("reset test done");
    conclude();
  end
endmodule : tb
